/* core/ictr_channel.sv */
// one 16-bit down-counting interval channel, counting modes zero to four
// Operation
// [RULE_01] count pulse is rise then fall; trigger is rise
// [RULE_02] mode 0: low after control, high at zero
// [RULE_03] mode 0: gate level enables counting only
// [RULE_04] mode 0: load without decrement, rise N+1
// [RULE_05] mode 0: first byte halts, forces low
// [RULE_06] mode 0: count loads even with gate low
// [RULE_07] mode 1: trigger loads count, output goes low
// [RULE_08] mode 1: retrigger restarts pulse, count reused
// [RULE_09] mode 1: new count used only on retrigger
// [RULE_10] mode 2: low one pulse at one, reload
// [RULE_11] mode 2: gate low forces high, trigger reloads
// [RULE_12] mode 2: load next pulse, low after N
// [RULE_13] mode 2: new count at trigger or period end
// [RULE_14] host never writes count one in mode 2
// [RULE_15] mode 3: square wave, period N, starts high
// [RULE_16] mode 3: gate low forces high, trigger reloads
// [RULE_17] mode 3: new count at trigger or half end
// [RULE_18] mode 3 even: load, step two, toggle
// [RULE_19] mode 3 odd: load N-1, extra high pulse
// [RULE_20] mode 4: one-pulse low strobe at expiry
// [RULE_21] mode 4: load without decrement, strobe N+1
// [RULE_22] mode 4: first byte ignored, second retriggers
// [RULE_23] load/decrement on fall, gate sampled on rise
// [RULE_24] control write resets logic and output at once
// [RULE_25] zero count means full range, wraps around
// [RULE_26] gate low holds count unchanged; mode 1 keeps counting while the gate is low
`timescale 1ns/1ps
module ictr_channel
    import ictr_pkg::*;
(
    input  wire logic   sys_clk,
    input  wire logic   rst,
    input  ictr_host_t  hostReq,
    input  wire logic   countClkPin,
    input  wire logic   triggerPin,
    output logic        wavePin,
    output ictr_status_t status
);
    logic        clkLevel;
    logic        clkRise;
    logic        clkFall;
    logic        gateLvl;
    logic        gateRise;
    ictr_state_t state_r;
    ictr_state_t state_nxt;
    logic [15:0] decOne;
    logic [15:0] decTwo;
    logic [15:0] evenLoad;

    ictr_pin_sync uClkSync (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .pinIn    (countClkPin),
        .pinLevel (clkLevel),
        .pinRise  (clkRise),
        .pinFall  (clkFall)
    );

    ictr_pin_sync uGateSync (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .pinIn    (triggerPin),
        .pinLevel (gateLvl),
        .pinRise  (gateRise),
        .pinFall  ()
    );

    assign decOne   = ictrDec(state_r.count, 1'b0, state_r.bcd);
    assign decTwo   = ictrDec(state_r.count, 1'b1, state_r.bcd);
    assign evenLoad = {state_r.holding[15:1], 1'b0}; // RULE_19

    always_comb begin
        state_nxt = state_r;
        // gate sampling and trigger latch on the count clock rise
        if (clkRise) begin // RULE_23
            state_nxt.gateS    = gateLvl;
            state_nxt.trigS    = state_r.trigFlag | gateRise; // RULE_01
            state_nxt.trigFlag = 1'b0;
        end else if (gateRise) begin
            state_nxt.trigFlag = 1'b1; // RULE_01
        end

        if (clkFall) begin // RULE_01
            state_nxt.trigS = 1'b0;
            case (state_r.mode)
                MODE_TERMINAL: begin
                    if (state_r.loadPend && !state_r.halted) begin
                        state_nxt.count    = state_r.holding; // RULE_04
                        state_nxt.loadPend = 1'b0; // RULE_06
                        state_nxt.started  = 1'b1;
                    end else if (state_r.gateS && state_r.started && !state_r.halted) begin
                        state_nxt.count = decOne; // RULE_03 RULE_25
                        if (decOne == CNT_ZERO) begin
                            state_nxt.wave = 1'b1; // RULE_02
                        end
                    end
                end
                MODE_ONESHOT: begin
                    if (state_r.trigS && state_r.hasCount) begin
                        state_nxt.count    = state_r.holding; // RULE_08 RULE_09
                        state_nxt.wave     = 1'b0; // RULE_07
                        state_nxt.loadPend = 1'b0;
                        state_nxt.started  = 1'b1;
                    end else if (state_r.started) begin
                        state_nxt.count = decOne; // RULE_25
                        if (decOne == CNT_ZERO) begin
                            state_nxt.wave = 1'b1; // RULE_07
                        end
                    end
                end
                MODE_RATE: begin
                    if (state_r.hasCount &&
                        (state_r.trigS || (state_r.loadPend && !state_r.started))) begin
                        state_nxt.count    = state_r.holding; // RULE_11 RULE_12 RULE_13
                        state_nxt.loadPend = 1'b0;
                        state_nxt.started  = 1'b1;
                        state_nxt.wave     = 1'b1;
                    end else if (state_r.started && state_r.gateS) begin
                        if (state_r.count == CNT_ONE) begin
                            state_nxt.count    = state_r.holding; // RULE_10 RULE_13
                            state_nxt.loadPend = 1'b0;
                            state_nxt.wave     = 1'b1;
                        end else begin
                            state_nxt.count = decOne; // RULE_26
                            if (decOne == CNT_ONE) begin
                                state_nxt.wave = 1'b0; // RULE_10
                            end
                        end
                    end
                end
                MODE_SQUARE: begin
                    if (state_r.hasCount &&
                        (state_r.trigS || (state_r.loadPend && !state_r.started))) begin
                        state_nxt.count    = evenLoad; // RULE_16 RULE_17
                        state_nxt.loadPend = 1'b0;
                        state_nxt.started  = 1'b1;
                        state_nxt.wave     = 1'b1; // RULE_15
                        state_nxt.oddExtra = 1'b0;
                    end else if (state_r.started && state_r.gateS) begin
                        if (state_r.oddExtra) begin
                            state_nxt.wave     = 1'b0; // RULE_19
                            state_nxt.count    = evenLoad;
                            state_nxt.oddExtra = 1'b0;
                            state_nxt.loadPend = 1'b0;
                        end else if (state_r.count == CNT_TWO) begin
                            if (state_r.holding[0] && state_r.wave) begin
                                state_nxt.count    = decTwo; // RULE_19
                                state_nxt.oddExtra = 1'b1;
                            end else begin
                                state_nxt.wave     = ~state_r.wave; // RULE_18
                                state_nxt.count    = evenLoad; // RULE_17
                                state_nxt.loadPend = 1'b0;
                            end
                        end else begin
                            state_nxt.count = decTwo; // RULE_18
                        end
                    end
                end
                MODE_STROBE: begin
                    if (state_r.loadPend) begin
                        state_nxt.count    = state_r.holding; // RULE_21 RULE_22
                        state_nxt.loadPend = 1'b0;
                        state_nxt.started  = 1'b1;
                        state_nxt.armed    = 1'b1;
                        state_nxt.wave     = 1'b1;
                    end else begin
                        if (!state_r.wave) begin
                            state_nxt.wave = 1'b1; // RULE_20
                        end
                        if (state_r.gateS && state_r.started) begin
                            state_nxt.count = decOne; // RULE_25
                            if (decOne == CNT_ZERO && state_r.armed) begin
                                state_nxt.wave  = 1'b0; // RULE_20
                                state_nxt.armed = 1'b0;
                            end
                        end
                    end
                end
                default: begin
                    state_nxt.wave = 1'b1;
                end
            endcase
        end

        // in modes 2 and 3, gate low during a low output forces it high without a count pulse
        if ((state_r.mode == MODE_RATE || state_r.mode == MODE_SQUARE) &&
            !gateLvl && !state_r.wave) begin
            state_nxt.wave = 1'b1; // RULE_11 RULE_16
        end

        if (hostReq.wrCtrl &&
            hostReq.wrData[CW_RW_MSB:CW_RW_LSB] != RW_LATCH) begin
            state_nxt.mode     = ictrDecodeMode(hostReq.wrData[CW_MODE_MSB:CW_MODE_LSB]);
            state_nxt.bcd      = hostReq.wrData[CW_BCD_BIT];
            state_nxt.rwSel    = hostReq.wrData[CW_RW_MSB:CW_RW_LSB];
            state_nxt.msbNext  = 1'b0; // RULE_24
            state_nxt.loadPend = 1'b0;
            state_nxt.started  = 1'b0;
            state_nxt.hasCount = 1'b0;
            state_nxt.halted   = 1'b0;
            state_nxt.oddExtra = 1'b0;
            state_nxt.armed    = 1'b0;
            state_nxt.trigFlag = 1'b0;
            state_nxt.trigS    = 1'b0;
            state_nxt.wave     = (ictrDecodeMode(hostReq.wrData[CW_MODE_MSB:CW_MODE_LSB])
                                  != MODE_TERMINAL); // RULE_02 RULE_24
        end else if (hostReq.wrCount) begin
            if (state_r.rwSel == RW_BOTH && !state_r.msbNext) begin
                state_nxt.lowByte = hostReq.wrData;
                state_nxt.msbNext = 1'b1;
                if (state_r.mode == MODE_TERMINAL) begin
                    state_nxt.halted = 1'b1; // RULE_05
                    state_nxt.wave   = 1'b0; // RULE_05
                end
            end else begin
                if (state_r.rwSel == RW_LSB) begin
                    state_nxt.holding = {BYTE_ZERO, hostReq.wrData};
                end else if (state_r.rwSel == RW_MSB) begin
                    state_nxt.holding = {hostReq.wrData, BYTE_ZERO};
                end else begin
                    state_nxt.holding = {hostReq.wrData, state_r.lowByte};
                end
                state_nxt.msbNext  = 1'b0;
                state_nxt.loadPend = 1'b1; // RULE_13 RULE_17 RULE_22
                state_nxt.hasCount = 1'b1; // RULE_07
                state_nxt.halted   = 1'b0;
                if (state_r.mode == MODE_TERMINAL) begin
                    state_nxt.wave = 1'b0; // RULE_02
                end
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_r          <= '0;
            state_r.mode     <= MODE_NONE;
            state_r.rwSel    <= RW_LSB;
            state_r.wave     <= 1'b1;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign wavePin            = state_r.wave;
    assign status.countValue  = state_r.count;
    assign status.loadPending = state_r.loadPend;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    chk_ctrl_init_out: assert property ( // RULE_24
        hostReq.wrCtrl && hostReq.wrData[CW_RW_MSB:CW_RW_LSB] != RW_LATCH
        |=> wavePin == (state_r.mode != MODE_TERMINAL) && !state_r.loadPend)
        else $error("control write did not set initial output");

    chk_first_byte_low: assert property ( // RULE_05
        hostReq.wrCount && !hostReq.wrCtrl && state_r.mode == MODE_TERMINAL &&
        state_r.rwSel == RW_BOTH && !state_r.msbNext
        |=> !wavePin && state_r.halted)
        else $error("first byte did not force output low");

    chk_gate_forces_high: assert property ( // RULE_11
        (state_r.mode == MODE_RATE || state_r.mode == MODE_SQUARE) && !gateLvl &&
        !wavePin && !hostReq.wrCtrl
        |=> wavePin)
        else $error("gate low did not force output high");

    chk_hold_gate_low: assert property ( // RULE_26
        clkFall && !state_r.gateS && !state_r.trigS && !state_r.loadPend &&
        state_r.mode inside {MODE_TERMINAL, MODE_RATE, MODE_SQUARE, MODE_STROBE} &&
        !hostReq.wrCtrl
        |=> state_r.count == $past(state_r.count))
        else $error("count moved while gate low");

    chk_load_no_dec: assert property ( // RULE_04
        clkFall && state_r.loadPend && !state_r.halted && !hostReq.wrCtrl &&
        !hostReq.wrCount && state_r.mode inside {MODE_TERMINAL, MODE_STROBE}
        |=> state_r.count == $past(state_r.holding))
        else $error("load pulse did not copy holding count");

    chk_oneshot_trig_low: assert property ( // RULE_07
        clkFall && state_r.mode == MODE_ONESHOT && state_r.trigS && state_r.hasCount &&
        !hostReq.wrCtrl
        |=> !wavePin && state_r.count == $past(state_r.holding))
        else $error("trigger did not start one-shot pulse");

    chk_rate_low_at_one: assert property ( // RULE_10
        clkFall && state_r.mode == MODE_RATE && state_r.started && state_r.gateS &&
        !state_r.trigS && state_r.count == CNT_TWO && !hostReq.wrCtrl
        |=> !wavePin && state_r.count == CNT_ONE)
        else $error("rate output not low at count one");

    chk_strobe_one_pulse: assert property ( // RULE_20
        state_r.mode == MODE_STROBE && !wavePin && clkFall && !hostReq.wrCtrl
        |=> wavePin)
        else $error("strobe lasted more than one pulse");

    chk_terminal_rise_zero: assert property ( // RULE_02
        state_r.mode == MODE_TERMINAL && $rose(wavePin) && !$past(hostReq.wrCtrl)
        |-> state_r.count == CNT_ZERO)
        else $error("terminal output rose off zero");

    chk_square_step_two: assert property ( // RULE_18
        clkFall && state_r.mode == MODE_SQUARE && state_r.started && state_r.gateS &&
        !state_r.trigS && !state_r.oddExtra && !state_r.bcd &&
        state_r.count != CNT_TWO && !hostReq.wrCtrl
        |=> state_r.count == $past(state_r.count) - CNT_TWO)
        else $error("square count did not step by two");

    cov_terminal_done: cover property (state_r.mode == MODE_TERMINAL && $rose(wavePin));
    cov_rate_pulse: cover property (state_r.mode == MODE_RATE && $fell(wavePin));
    cov_square_toggle: cover property (state_r.mode == MODE_SQUARE && $rose(wavePin));
    cov_oneshot_retrig: cover property (
        state_r.mode == MODE_ONESHOT && !wavePin && clkFall && state_r.trigS);
endmodule

/* core/ictr_pin_sync.sv */
// two-flop synchroniser with level and edge pulses for one input pin
`timescale 1ns/1ps
module ictr_pin_sync (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic pinIn,
    output logic      pinLevel,
    output logic      pinRise,
    output logic      pinFall
);
    typedef struct packed {
        logic meta;
        logic stable;
        logic prev;
    } ictr_sync_t;

    ictr_sync_t sync_r;
    ictr_sync_t sync_nxt;

    // only the second stage reads the first
    always_comb begin
        sync_nxt        = sync_r;
        sync_nxt.meta   = pinIn;
        sync_nxt.stable = sync_r.meta;
        sync_nxt.prev   = sync_r.stable;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sync_r <= '0;
        end else begin
            sync_r <= sync_nxt;
        end
    end

    assign pinLevel = sync_r.stable;
    assign pinRise  = sync_r.stable & ~sync_r.prev;
    assign pinFall  = ~sync_r.stable & sync_r.prev;
endmodule

/* include/ictr_pkg.sv */
// shared types, field positions and helpers of the interval counter channel
package ictr_pkg;

    // control word field positions
    localparam int CW_BCD_BIT  = 0;
    localparam int CW_MODE_LSB = 1;
    localparam int CW_MODE_MSB = 3;
    localparam int CW_RW_LSB   = 4;
    localparam int CW_RW_MSB   = 5;

    // byte access selection codes
    localparam logic [1:0] RW_LATCH = 2'h0;
    localparam logic [1:0] RW_LSB   = 2'h1;
    localparam logic [1:0] RW_MSB   = 2'h2;
    localparam logic [1:0] RW_BOTH  = 2'h3;

    localparam logic [15:0] CNT_ZERO  = 16'h0000;
    localparam logic [15:0] CNT_ONE   = 16'h0001;
    localparam logic [15:0] CNT_TWO   = 16'h0002;
    localparam logic [7:0]  BYTE_ZERO = 8'h00;
    localparam logic [3:0]  BCD_TEN   = 4'hA;

    typedef enum logic [2:0] {
        MODE_TERMINAL,
        MODE_ONESHOT,
        MODE_RATE,
        MODE_SQUARE,
        MODE_STROBE,
        MODE_NONE
    } ictr_mode_t;

    // host write request, same clock as the channel
    typedef struct packed {
        logic       wrCtrl;
        logic       wrCount;
        logic [7:0] wrData;
    } ictr_host_t;

    typedef struct packed {
        logic [15:0] countValue;
        logic        loadPending;
    } ictr_status_t;

    typedef struct packed {
        logic [15:0] count;
        logic [15:0] holding;
        logic [7:0]  lowByte;
        ictr_mode_t  mode;
        logic        bcd;
        logic [1:0]  rwSel;
        logic        msbNext;
        logic        loadPend;
        logic        started;
        logic        hasCount;
        logic        halted;
        logic        oddExtra;
        logic        armed;
        logic        trigFlag;
        logic        trigS;
        logic        gateS;
        logic        wave;
    } ictr_state_t;

    function automatic ictr_mode_t ictrDecodeMode(input logic [2:0] code);
        ictr_mode_t m;
        m = MODE_NONE;
        case (code)
            3'h0: m = MODE_TERMINAL;
            3'h1: m = MODE_ONESHOT;
            3'h2: m = MODE_RATE;
            3'h3: m = MODE_SQUARE;
            3'h4: m = MODE_STROBE;
            default: m = MODE_NONE;
        endcase
        return m;
    endfunction

    // step down by one or two, binary or four-digit bcd, wrapping at zero
    function automatic logic [15:0] ictrDec(input logic [15:0] v, input logic two,
                                            input logic bcd);
        logic [16:0] bin;
        logic [15:0] r;
        logic [3:0]  dig;
        logic [3:0]  sub;
        bin = {1'b0, v} - (two ? 17'h0_0002 : 17'h0_0001);
        r   = v;
        sub = two ? 4'h2 : 4'h1;
        for (int i = 0; i < 4; i++) begin
            dig = v[i*4 +: 4];
            if (dig < sub) begin
                r[i*4 +: 4] = dig + BCD_TEN - sub;
                sub         = 4'h1;
            end else begin
                r[i*4 +: 4] = dig - sub;
                sub         = 4'h0;
            end
        end
        return bcd ? r : bin[15:0];
    endfunction

endpackage

/* tb/ictr_channel_tb.sv */
// self-checking bench of the interval counter channel
`timescale 1ns/1ps
module ictr_channel_tb;
    import ictr_pkg::*;
    logic         sys_clk;
    logic         rst;
    ictr_host_t   hostReq;
    logic         countClkPin;
    logic         triggerPin;
    logic         wavePin;
    ictr_status_t status;
    int           n_fail;
    int           tests_run;
    logic [31:0]  lfsrState;
    int           nCount;
    int           kLast;
    int           cLeft;

    ictr_host_model u_host (.sys_clk(sys_clk), .hostReq(hostReq));
    ictr_channel u_dut (.sys_clk(sys_clk), .rst(rst), .hostReq(hostReq),
        .countClkPin(countClkPin), .triggerPin(triggerPin), .wavePin(wavePin),
        .status(status));

    function automatic logic [31:0] lfsrNext(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // expected wave after k count pulses from the write or trigger
    function automatic logic expWave(input int mode, input int n, input int k);
        int ph;
        ph = (k - 1) % n;
        case (mode)
            0: return (k >= n + 1);
            1: return !(k >= 1 && k <= n);
            2: return !((k % n) == 0);
            3: return (ph < (n + 1) / 2);
            default: return (k != n + 1);
        endcase
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic chkWave(input logic exp);
        chk({15'h0000, wavePin}, {15'h0000, exp});
    endtask

    // one count pulse: rise, then fall, then let the fall act
    task automatic pulse();
        @(negedge sys_clk);
        countClkPin = 1'b1;
        repeat (4) @(negedge sys_clk);
        countClkPin = 1'b0;
        repeat (6) @(negedge sys_clk);
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    initial begin
        #400000;
        n_fail++;
        complete_run();
    end

    initial begin
        rst = 1'b1;
        countClkPin = 1'b0;
        triggerPin = 1'b1;
        n_fail = 0;
        tests_run = 0;
        lfsrState = 32'h0967_7d3a;
        repeat (16) @(negedge sys_clk);
        rst = 1'b0;
        @(negedge sys_clk);
        for (int m = 0; m < 5; m++) begin
            lfsrState = lfsrNext(lfsrState);
            nCount = 2 + int'(lfsrState[2:0]);
            triggerPin = (m != 1);
            u_host.writeCtrl({2'b00, RW_BOTH, 3'(m), 1'b0});
            chkWave(m != 0);
            u_host.writeCount(16'(nCount));
            chk({15'h0000, status.loadPending}, 16'h0001);
            if (m == 1) begin
                pulse();
                chkWave(1'b1);
                triggerPin = 1'b1;
                repeat (4) @(negedge sys_clk);
            end
            kLast = 2 * nCount + (nCount + 1) / 2 + 1;
            for (int k = 1; k <= kLast; k++) begin
                pulse();
                if (k == 1) begin
                    chk({15'h0000, status.loadPending}, 16'h0000);
                end
                chkWave(expWave(m, nCount, k));
            end
            if (m == 0) begin
                u_host.writeByte(8'h05);
                chkWave(1'b0);
                triggerPin = 1'b0;
                u_host.writeByte(8'h00);
                pulse();
                chk(status.countValue, 16'h0005);
                pulse();
                pulse();
                chk(status.countValue, 16'h0005);
                triggerPin = 1'b1;
                repeat (4) @(negedge sys_clk);
                repeat (4) pulse();
                chkWave(1'b0);
                pulse();
                chkWave(1'b1);
            end else if (m == 1) begin
                for (int r = 0; r < 2; r++) begin
                    triggerPin = 1'b0;
                    repeat (4) @(negedge sys_clk);
                    triggerPin = 1'b1;
                    repeat (4) @(negedge sys_clk);
                    pulse();
                    chkWave(1'b0);
                    if (r == 0) begin
                        u_host.writeCount(16'h000b);
                    end
                    repeat ((r == 0) ? nCount - 1 : 10) pulse();
                    chkWave(1'b0);
                    pulse();
                    chkWave(1'b1);
                end
            end else if (m == 2) begin
                cLeft = nCount - ((kLast - 1) % nCount);
                u_host.writeCount(16'h0003);
                for (int k = 1; k <= cLeft + 5; k++) begin
                    pulse();
                    chkWave(!((k - cLeft + 1) % 3 == 0 && k >= cLeft - 1));
                end
                triggerPin = 1'b0;
                repeat (6) @(negedge sys_clk);
                chkWave(1'b1);
                triggerPin = 1'b1;
                repeat (4) @(negedge sys_clk);
                repeat (2) pulse();
                chkWave(1'b1);
                pulse();
                chkWave(1'b0);
            end else if (m == 3) begin
                triggerPin = 1'b0;
                repeat (6) @(negedge sys_clk);
                chkWave(1'b1);
                u_host.writeCount(16'h000a);
                triggerPin = 1'b1;
                repeat (4) @(negedge sys_clk);
                for (int k = 1; k <= 11; k++) begin
                    pulse();
                    chkWave(expWave(3, 10, k));
                end
            end else begin
                u_host.writeByte(8'h03);
                pulse();
                chk(status.countValue, 16'(nCount - kLast));
                u_host.writeByte(8'h00);
                repeat (3) pulse();
                chkWave(1'b1);
                pulse();
                chkWave(1'b0);
            end
        end
        for (int b = 0; b < 2; b++) begin
            u_host.writeCtrl({2'b00, RW_BOTH, 3'h0, b[0]});
            u_host.writeCount(16'h0000);
            pulse();
            pulse();
            chk(status.countValue, (b == 1) ? 16'h9999 : 16'hffff);
        end
        u_host.writeCtrl({2'b00, RW_LSB, 3'h0, 1'b0});
        u_host.writeByte(8'h03);
        pulse();
        chk(status.countValue, 16'h0003);
        u_host.writeCtrl({2'b00, RW_MSB, 3'h0, 1'b0});
        u_host.writeByte(8'h01);
        pulse();
        chk(status.countValue, 16'h0100);
        u_host.writeCtrl({2'b00, RW_LATCH, 3'h2, 1'b0});
        chkWave(1'b0);
        u_host.writeCtrl({2'b00, RW_BOTH, 3'h5, 1'b0});
        chkWave(1'b1);
        complete_run();
    end
endmodule

/* tb/ictr_host_model.sv */
// host side model issuing control words and count bytes
`timescale 1ns/1ps
module ictr_host_model
    import ictr_pkg::*;
(
    input  wire logic sys_clk,
    output ictr_host_t hostReq
);
    logic [2:0] curMode;

    initial begin
        hostReq = '0;
        curMode = 3'h0;
    end

    // one-cycle strobe; released data lines show the inverse value
    task automatic strobe(input logic ctrl, input logic [7:0] data);
        @(negedge sys_clk);
        hostReq = '{wrCtrl: ctrl, wrCount: !ctrl, wrData: data};
        @(negedge sys_clk);
        hostReq = '{wrCtrl: 1'b0, wrCount: 1'b0, wrData: ~data};
        @(negedge sys_clk);
    endtask

    task automatic writeCtrl(input logic [7:0] data);
        curMode = data[3:1];
        strobe(1'b1, data);
    endtask

    task automatic writeByte(input logic [7:0] data);
        strobe(1'b0, data);
    endtask

    task automatic writeCount(input logic [15:0] v);
        logic [15:0] w;
        w = v;
        if (curMode == 3'h2 && w == 16'h0001) begin
            w = 16'h0002;
        end
        strobe(1'b0, w[7:0]);
        strobe(1'b0, w[15:8]);
    endtask
endmodule
